// *** design/lsp_pkg.sv ***
package lsp_pkg;

  // ----------------------------------------
  // port role and power-control encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSP_PLAIN,
    LSP_SW_UP,
    LSP_SW_DN
  } lsp_role_t;

  localparam logic [1:0] LSP_CTL_OFF = 2'h0;
  localparam logic [1:0] LSP_CTL_L0S = 2'h1;
  localparam logic [1:0] LSP_CTL_L1 = 2'h2;
  localparam logic [1:0] LSP_CTL_BOTH = 2'h3;
  localparam logic [1:0] LSP_CTL_RST = LSP_CTL_OFF;
  localparam int LSP_L0S_BIT = 0;
  localparam int LSP_L1_BIT = 1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int LSP_CLK_NS = 5;
  localparam int LSP_IDLE_MAX_NS = 7000;
  // longest time, so rounded down
  localparam int LSP_IDLE_CYC = LSP_IDLE_MAX_NS / LSP_CLK_NS;
  localparam int LSP_IDLE_W = $clog2(LSP_IDLE_CYC + 1);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic tlp;
    logic credit;
    logic dllp;
  } lsp_pend_t;

  typedef struct packed {
    logic l0s_en;
    logic l1_en;
  } lsp_en_t;

  function automatic logic lsp_func_idle(lsp_pend_t p);
    return (!p.tlp || !p.credit) && !p.dllp;
  endfunction

  function automatic logic lsp_has_traffic(lsp_pend_t p);
    return p.tlp || p.dllp;
  endfunction

endpackage

// *** design/lsp_pwr_ctl.sv ***
`timescale 1ns/100ps
module lsp_pwr_ctl #(
  parameter logic [1:0] CAP = lsp_pkg::LSP_CTL_BOTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ctl_we_i,
  input wire logic [1:0] ctl_wdata_i,
  output logic [1:0] field_o,
  output lsp_pkg::lsp_en_t en_o
);

  typedef struct packed {
    logic [1:0] field;
  } lsp_ctl_st_t;

  lsp_ctl_st_t st;
  lsp_ctl_st_t next_st;

  always_comb begin
    next_st = st;
    if (ctl_we_i) begin
      next_st.field = ctl_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.field <= lsp_pkg::LSP_CTL_RST;
    end else begin
      st <= next_st;
    end
  end

  // a state the port cannot do is never enabled, whatever is written
  assign field_o = st.field;
  assign en_o.l0s_en = st.field[lsp_pkg::LSP_L0S_BIT] && CAP[lsp_pkg::LSP_L0S_BIT];
  assign en_o.l1_en = st.field[lsp_pkg::LSP_L1_BIT] && CAP[lsp_pkg::LSP_L1_BIT];

  AST_DECODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctl_we_i |=> (en_o.l1_en == ($past(ctl_wdata_i[1]) && CAP[1]))
      && (en_o.l0s_en == ($past(ctl_wdata_i[0]) && CAP[0])))
    else $error("power-control decode wrong");

endmodule

// *** design/lsp_idle_timer.sv ***
`timescale 1ns/100ps
module lsp_idle_timer #(
  parameter int THR = lsp_pkg::LSP_IDLE_CYC,
  parameter int W = lsp_pkg::LSP_IDLE_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic idle_i,
  output logic hit_o
);

  localparam logic [W-1:0] THR_M1 = W'(THR - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic hit;
  } lsp_tmr_st_t;

  lsp_tmr_st_t st;
  lsp_tmr_st_t next_st;

  // any break in idleness restarts the count
  always_comb begin
    next_st = st;
    if (!run_i || !idle_i) begin
      next_st.cnt = '0;
      next_st.hit = 1'b0;
    end else if (st.cnt >= THR_M1) begin
      next_st.hit = 1'b1;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit_o = st.hit;

  AST_HIT_NEEDS_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(hit_o) |-> $past(idle_i) && $past(run_i) && ($past(st.cnt) == THR_M1))
    else $error("idle threshold reached without full idle run");

endmodule

// *** design/lsp_link_policy.sv ***
`timescale 1ns/100ps
// Functional notes
// - each side steers only its transmit lanes
// - fast standby disabled means never enter it
// - tolerate peer-driven receive standby and return
// - enter standby after idle, within 7 us
// - multi-function upstream port idle when all idle
// - plain port idle: no DLLP, no sendable TLP
// - switch up idle also needs downstream rx quiet
// - switch down idle also needs upstream rx quiet
// - queued TLP or DLLP starts standby exit
// - exit never waits on flow-control credits
// - early exit allowed on predicted traffic
// - upstream port may exit when it must talk
// - downstream rx exit wakes switch upstream tx
// - downstream port may exit when it must talk
// - upstream rx exit wakes downstream standby links
// - propagated exit skips active or low-power links
// - deep standby wake latency reported when supported
// - deep standby enable resets to disabled
// - upstream port may start deep standby entry
// - decode two-bit enable field
// - link timers keep running during standby
module lsp_link_policy #(
  parameter lsp_pkg::lsp_role_t ROLE = lsp_pkg::LSP_PLAIN,
  parameter int N_FUNC = 1,
  parameter int N_DN = 4,
  parameter logic [1:0] CAP = lsp_pkg::LSP_CTL_BOTH,
  parameter logic [2:0] L1_LAT = 3'h4,
  parameter int IDLE_CYC = lsp_pkg::LSP_IDLE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ctl_we_i,
  input wire logic [1:0] ctl_wdata_i,
  input lsp_pkg::lsp_pend_t [N_FUNC-1:0] pend_i,
  input wire logic predict_i,
  input wire logic need_comm_i,
  input wire logic phy_tx_l0_i,
  input wire logic rx_l0s_i,
  input wire logic [N_DN-1:0] dn_rx_active_i,
  input wire logic [N_DN-1:0] dn_rx_exit_i,
  input wire logic up_rx_active_i,
  input wire logic up_rx_exit_i,
  input wire logic dn_dev_lowpwr_i,
  output logic tx_standby_o,
  output logic tx_wake_o,
  output logic port_idle_o,
  output logic deep_entry_ok_o,
  output logic rx_standby_seen_o,
  output logic [1:0] link_power_enable_field_o,
  output logic [1:0] link_power_capability_field_o,
  output logic [2:0] deep_standby_wake_latency_field_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_STANDBY,
    ST_EXIT
  } lsp_state_t;

  typedef struct packed {
    lsp_state_t state;
    logic tx_standby;
    logic tx_wake;
    logic idle;
    logic deep_ok;
    logic rx_seen;
  } lsp_st_t;

  lsp_st_t st;
  lsp_st_t next_st;

  lsp_pkg::lsp_en_t en;
  logic funcs_idle;
  logic any_traffic;
  logic peer_quiet;
  logic port_idle;
  logic prop_exit;
  logic wake_now;
  logic idle_hit;

  // ----------------------------------------
  // software enable field
  // ----------------------------------------
  lsp_pwr_ctl #(
    .CAP(CAP)
  ) u_ctl (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ctl_we_i(ctl_we_i),
    .ctl_wdata_i(ctl_wdata_i),
    .field_o(link_power_enable_field_o),
    .en_o(en)
  );

  // ----------------------------------------
  // idle detection
  // ----------------------------------------
  always_comb begin
    funcs_idle = 1'b1;
    any_traffic = 1'b0;
    for (int i = 0; i < N_FUNC; i++) begin
      funcs_idle = funcs_idle && lsp_pkg::lsp_func_idle(pend_i[i]);
      any_traffic = any_traffic || lsp_pkg::lsp_has_traffic(pend_i[i]);
    end
  end

  // receive lanes in L0, recovery or configuration count as busy
  always_comb begin
    case (ROLE)
      lsp_pkg::LSP_SW_UP: peer_quiet = ~|dn_rx_active_i;
      lsp_pkg::LSP_SW_DN: peer_quiet = !up_rx_active_i;
      default: peer_quiet = 1'b1;
    endcase
  end

  assign port_idle = funcs_idle && peer_quiet;

  lsp_idle_timer #(
    .THR(IDLE_CYC),
    .W($clog2(IDLE_CYC + 1))
  ) u_tmr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(en.l0s_en && (st.state == ST_ACTIVE)),
    .idle_i(port_idle),
    .hit_o(idle_hit)
  );

  // ----------------------------------------
  // exit causes
  // ----------------------------------------
  // propagated exits from the other side of a switch
  always_comb begin
    case (ROLE)
      lsp_pkg::LSP_SW_UP: prop_exit = |dn_rx_exit_i;
      // a link to a sleeping device wakes only when traffic is routed to it
      lsp_pkg::LSP_SW_DN: prop_exit = up_rx_exit_i && !dn_dev_lowpwr_i;
      default: prop_exit = 1'b0;
    endcase
  end

  // credits are not looked at here, so a drained link can still wake
  assign wake_now = any_traffic
    || predict_i
    || need_comm_i
    || prop_exit;

  // ----------------------------------------
  // transmit standby control
  // ----------------------------------------
  // only the transmit side is steered; receive standby is observed, never forced
  always_comb begin
    next_st = st;
    next_st.tx_wake = 1'b0;
    next_st.idle = port_idle;
    next_st.rx_seen = rx_l0s_i;
    next_st.deep_ok = (ROLE != lsp_pkg::LSP_SW_DN) && en.l1_en
      && port_idle && !wake_now;
    case (st.state)
      ST_ACTIVE: begin
        if (en.l0s_en && idle_hit && port_idle && !wake_now) begin
          next_st.state = ST_STANDBY;
          next_st.tx_standby = 1'b1;
        end
      end
      ST_STANDBY: begin
        if (wake_now || !en.l0s_en) begin
          next_st.state = ST_EXIT;
          next_st.tx_standby = 1'b0;
          next_st.tx_wake = 1'b1;
        end
      end
      ST_EXIT: begin
        if (phy_tx_l0_i) begin
          next_st.state = ST_ACTIVE;
        end
      end
      default: begin
        next_st.state = ST_ACTIVE;
        next_st.tx_standby = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.state <= ST_ACTIVE;
      st.tx_standby <= 1'b0;
      st.tx_wake <= 1'b0;
      st.idle <= 1'b0;
      st.deep_ok <= 1'b0;
      st.rx_seen <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // standby only gates the lanes; replay and ack timers elsewhere keep counting
  assign tx_standby_o = st.tx_standby;
  assign tx_wake_o = st.tx_wake;
  assign port_idle_o = st.idle;
  assign deep_entry_ok_o = st.deep_ok;
  assign rx_standby_seen_o = st.rx_seen;
  assign link_power_capability_field_o = CAP;
  // latency reads zero when deep standby is not offered
  assign deep_standby_wake_latency_field_o = CAP[lsp_pkg::LSP_L1_BIT] ? L1_LAT : 3'h0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_NO_ENTRY_DISABLED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(tx_standby_o) |-> $past(en.l0s_en))
    else $error("standby entered while disabled");

  AST_DISABLE_LEAVES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && !en.l0s_en |=> !tx_standby_o && tx_wake_o)
    else $error("standby kept after disable");

  AST_ENTRY_NEEDS_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(tx_standby_o) |-> $past(port_idle) && $past(idle_hit))
    else $error("standby entered without idle period");

  AST_EXIT_ON_TRAFFIC: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && any_traffic |=> tx_wake_o ##1 !tx_wake_o)
    else $error("queued traffic did not wake transmitter");

  AST_EXIT_NO_CREDIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && pend_i[0].tlp && !pend_i[0].credit |=> !tx_standby_o)
    else $error("exit waited on credits");

  AST_EARLY_EXIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && predict_i |=> tx_wake_o)
    else $error("predicted traffic did not wake transmitter");

  AST_UP_PROP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ROLE == lsp_pkg::LSP_SW_UP) && tx_standby_o && (|dn_rx_exit_i) |=> tx_wake_o)
    else $error("downstream exit not propagated upstream");

  AST_DN_PROP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ROLE == lsp_pkg::LSP_SW_DN) && tx_standby_o && up_rx_exit_i && !dn_dev_lowpwr_i
      |=> tx_wake_o)
    else $error("upstream exit not propagated downstream");

  AST_LOWPWR_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ROLE == lsp_pkg::LSP_SW_DN) && tx_standby_o && en.l0s_en && dn_dev_lowpwr_i
      && !any_traffic && !predict_i && !need_comm_i |=> tx_standby_o)
    else $error("low-power link woken by propagation");

  AST_DEEP_ROLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    deep_entry_ok_o |-> (ROLE != lsp_pkg::LSP_SW_DN) && $past(en.l1_en))
    else $error("deep standby offered without enable");

  AST_DEEP_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !$past(nrst_i) |-> !en.l1_en && !deep_entry_ok_o)
    else $error("deep standby enabled out of reset");

  AST_WAKE_PULSE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_wake_o |=> !tx_wake_o)
    else $error("wake longer than one cycle");

  AST_WAKE_FROM_STANDBY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_wake_o |-> $past(tx_standby_o) && !tx_standby_o)
    else $error("wake without prior standby");

  AST_NOT_BOTH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(tx_standby_o && tx_wake_o))
    else $error("standby and wake together");

  AST_DLLP_WAKE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && pend_i[0].dllp |=> tx_wake_o)
    else $error("pending dllp did not wake transmitter");

  AST_WAKE_BLOCKS_ENTRY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wake_now && !tx_standby_o |=> !tx_standby_o)
    else $error("standby entered with a wake cause");

  AST_NEED_WAKE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && need_comm_i |=> tx_wake_o)
    else $error("need to talk did not wake transmitter");

  AST_EXIT_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == ST_EXIT) && !phy_tx_l0_i |=> (st.state == ST_EXIT))
    else $error("exit left before lanes back in L0");

  AST_EXIT_DONE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == ST_EXIT) && phy_tx_l0_i |=> (st.state == ST_ACTIVE))
    else $error("exit not finished when lanes back in L0");

  AST_EXIT_NO_STANDBY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state == ST_EXIT) |=> !tx_standby_o)
    else $error("standby re-entered without a fresh idle period");

  AST_STANDBY_STAYS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_standby_o && !wake_now && en.l0s_en |=> tx_standby_o)
    else $error("standby left without a cause");

  AST_TIMER_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st.state != ST_ACTIVE) |=> !idle_hit)
    else $error("idle timer ran outside active state");

  AST_FUNC_BUSY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !funcs_idle && !tx_standby_o |=> !tx_standby_o)
    else $error("standby entered with a busy function");

  AST_UP_BUSY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ROLE == lsp_pkg::LSP_SW_UP) && (|dn_rx_active_i) && !tx_standby_o |=> !tx_standby_o)
    else $error("standby entered with downstream rx active");

  AST_DN_BUSY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ROLE == lsp_pkg::LSP_SW_DN) && up_rx_active_i && !tx_standby_o |=> !tx_standby_o)
    else $error("standby entered with upstream rx active");

  AST_IDLE_REG: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && port_idle |=> port_idle_o)
    else $error("idle indication lost");

  AST_BUSY_REG: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && !port_idle |=> !port_idle_o)
    else $error("busy port shown idle");

  AST_RX_SEEN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && rx_l0s_i |=> rx_standby_seen_o)
    else $error("receive standby not observed");

  AST_RX_BACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && !rx_l0s_i |=> !rx_standby_seen_o)
    else $error("receive return not observed");

  AST_RX_NO_TX: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_l0s_i && (st.state == ST_ACTIVE) && !idle_hit |=> !tx_standby_o)
    else $error("receive standby forced transmit standby");

  AST_ENABLE_SEEN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctl_we_i |=> (link_power_enable_field_o == $past(ctl_wdata_i)))
    else $error("enable field not updated");

  AST_NO_CAP_NO_DEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !CAP[lsp_pkg::LSP_L1_BIT] |-> !en.l1_en && !deep_entry_ok_o)
    else $error("deep standby enabled without support");

  AST_RST_QUIET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !$past(nrst_i) |-> !tx_standby_o && !tx_wake_o)
    else $error("standby or wake out of reset");

endmodule

// *** testbench/lsp_peer_model.sv ***
`timescale 1ns/100ps
module lsp_peer_model #(
  parameter int SLOW = 6
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tx_wake_i,
  input wire logic slow_i,
  input wire logic rx_sleep_i,
  output logic phy_tx_l0_o,
  output logic rx_l0s_o
);
  // ----------------------------------------
  // far port: lane resync after a wake, own tx standby
  // ----------------------------------------
  int cnt;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      phy_tx_l0_o <= 1'b1;
      rx_l0s_o <= 1'b0;
    end else begin
      rx_l0s_o <= rx_sleep_i;
      if (tx_wake_i) begin
        phy_tx_l0_o <= 1'b0;
        cnt <= slow_i ? SLOW : 2;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else begin
        phy_tx_l0_o <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  localparam int IDLE = 8;
  localparam logic [5:0] IDL = 6'h12;
  logic clk_i, nrst_i, ctl_we, predict, need, slow, rx_sleep, phy_l0, rx_l0s;
  logic [1:0] wdata, dn_act, dn_exit, field, cap;
  logic [2:0] lat;
  logic sb, wake, pidle, deep_ok, rx_seen;
  lsp_pkg::lsp_pend_t [1:0] pend;
  int n_mismatch = 0;
  int check_count = 0;
  int n;

  lsp_link_policy #(.ROLE(lsp_pkg::LSP_SW_UP), .N_FUNC(2), .N_DN(2), .IDLE_CYC(IDLE)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ctl_we_i(ctl_we), .ctl_wdata_i(wdata),
    .pend_i(pend), .predict_i(predict), .need_comm_i(need), .phy_tx_l0_i(phy_l0),
    .rx_l0s_i(rx_l0s), .dn_rx_active_i(dn_act), .dn_rx_exit_i(dn_exit),
    .up_rx_active_i(1'b0), .up_rx_exit_i(1'b0), .dn_dev_lowpwr_i(1'b0),
    .tx_standby_o(sb), .tx_wake_o(wake), .port_idle_o(pidle), .deep_entry_ok_o(deep_ok),
    .rx_standby_seen_o(rx_seen), .link_power_enable_field_o(field),
    .link_power_capability_field_o(cap), .deep_standby_wake_latency_field_o(lat));

  lsp_peer_model peer (.clk_i(clk_i), .nrst_i(nrst_i), .tx_wake_i(wake), .slow_i(slow),
    .rx_sleep_i(rx_sleep), .phy_tx_l0_o(phy_l0), .rx_l0s_o(rx_l0s));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: %s", $time, m);
    end
  endtask

  task automatic setin(input logic [5:0] p, input logic pr, input logic nc);
    @(posedge clk_i);
    pend <= p;
    predict <= pr;
    need <= nc;
  endtask

  // fast standby is only enabled because the peer model supports it
  task automatic wr(input logic [1:0] d);
    @(posedge clk_i);
    ctl_we <= 1'b1;
    wdata <= d;
    @(posedge clk_i);
    ctl_we <= 1'b0;
  endtask

  task automatic enter(output int k);
    setin(IDL, 1'b0, 1'b0);
    k = 0;
    while (sb !== 1'b1 && k < IDLE + 6) begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(field === 2'h0 && sb === 1'b0, "enable field not cleared");
    chk(cap === 2'h3 && lat === 3'h4, "capability or latency wrong");
  endtask

  task automatic t_decode;
    for (int d = 0; d < 4; d++) begin
      wr(d[1:0]);
      setin(IDL, 1'b0, 1'b0);
      repeat (IDLE + 10) @(posedge clk_i);
      #1;
      chk(field === d[1:0], "field readback");
      chk(sb === d[0], "standby vs enable");
      chk(deep_ok === d[1], "deep entry permission");
    end
    wr(2'h1);
  endtask

  task automatic t_timer;
    setin(6'h01, 1'b0, 1'b0);
    repeat (IDLE + 8) @(posedge clk_i);
    setin(IDL, 1'b0, 1'b0);
    repeat (IDLE - 2) @(posedge clk_i);
    setin(6'h01, 1'b0, 1'b0);
    enter(n);
    chk(n >= IDLE + 1 && n <= IDLE + 3, "idle count not restarted");
  endtask

  task automatic t_wake;
    for (int c = 0; c < 5; c++) begin
      enter(n);
      chk(sb === 1'b1, "no standby before wake");
      @(posedge clk_i);
      slow <= c[0];
      if (c == 0) pend <= 6'h22;
      if (c == 1) pend <= 6'h13;
      predict <= (c == 2);
      need <= (c == 3);
      dn_exit <= (c == 4) ? 2'h2 : 2'h0;
      @(posedge clk_i);
      dn_exit <= 2'h0;
      #1;
      chk(sb === 1'b0 && wake === 1'b1, "wake cause ignored");
      @(posedge clk_i);
      #1;
      chk(wake === 1'b0, "wake not a pulse");
      setin(6'h01, 1'b0, 1'b0);
      repeat (10) @(posedge clk_i);
    end
  endtask

  task automatic t_block;
    setin(6'h11, 1'b0, 1'b0);
    repeat (IDLE + 8) @(posedge clk_i);
    #1;
    chk(sb === 1'b0 && pidle === 1'b0, "one busy function ignored");
    @(posedge clk_i);
    dn_act <= 2'h1;
    setin(IDL, 1'b0, 1'b0);
    repeat (IDLE + 8) @(posedge clk_i);
    #1;
    chk(sb === 1'b0, "active downstream rx ignored");
    @(posedge clk_i);
    dn_act <= 2'h0;
    rx_sleep <= 1'b1;
    enter(n);
    chk(sb === 1'b1 && rx_seen === 1'b1, "rx standby disturbs tx");
    @(posedge clk_i);
    rx_sleep <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(rx_seen === 1'b0 && sb === 1'b1, "rx return disturbs tx");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end

  initial begin
    nrst_i = 1'b0;
    ctl_we = 1'b0;
    wdata = 2'h0;
    pend = 6'h01;
    predict = 1'b0;
    need = 1'b0;
    slow = 1'b0;
    rx_sleep = 1'b0;
    dn_act = 2'h0;
    dn_exit = 2'h0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset();
    t_decode();
    t_timer();
    t_wake();
    t_block();
    test_done();
  end
endmodule
